// File: shared/rr_exec_regs.vh
// Purpose: Constants for the return and rotate execution block
// Assumes: 14-bit instruction word, 8-bit data path
// Notes: Encodings are local to this block
`ifndef RR_EXEC_REGS_VH
`define RR_EXEC_REGS_VH
`define OPCODE_W 14
`define PC_W 15
`define DATA_W 8
`define FADDR_W 7
`define DEST_BIT 7
`define OP_RETURN 14'h0008
`define OP_RET_LIT_MASK 14'h3f00
`define OP_RET_LIT_CODE 14'h3400
`define OP_ROT_MASK 14'h3f00
`define OP_ROT_LEFT_CODE 14'h0d00
`define OP_ROT_RIGHT_CODE 14'h0c00
`define RETURN_CYCLES 2
`define ROTATE_CYCLES 1
`endif

// File: logic/rotate_unit.v
// Purpose: Rotate an operand through carry
// Assumes: Combinational, 8-bit operand
// Notes: Direction selected by dir_left_i
`timescale 1ns/100ps
`default_nettype none
module rotate_unit #(
   parameter WIDTH = 8
) (
   input wire [WIDTH-1:0] operand_i,
   input wire carry_i,
   input wire dir_left_i,
   output wire [WIDTH-1:0] result_o,
   output wire carry_o
);
   // Left: msb to carry, carry to lsb; right: lsb to carry, carry to msb
   assign result_o = dir_left_i ? {operand_i[WIDTH-2:0], carry_i} :
      {carry_i, operand_i[WIDTH-1:1]};
   assign carry_o = dir_left_i ? operand_i[WIDTH-1] : operand_i[0];
endmodule // rotate_unit
`default_nettype wire

// File: logic/return_and_rotate_exec.v
// Purpose: Execute return, return with literal and rotates through carry
// Assumes: Decoder holds opcode stable with op_valid_i until done
// Notes: File operand value is supplied by the register file
// Behaviour
// - A return pops the stack and loads the popped top into the PC in two cycles, flags untouched.
// - A return with literal writes its 8-bit immediate into the working register.
// - A return with literal also pops into the PC, is one word, two cycles, and changes no flag.
// - A left rotate shifts the file operand left through carry in one cycle, touching only carry.
// - The left rotate result goes to W when the destination bit is 0, else to the file register.
// - A right rotate shifts the file operand right through carry, touching only carry.
// - The right rotate result goes to W when the destination bit is 0, else to the file register.
`timescale 1ns/100ps
`default_nettype none
`include "rr_exec_regs.vh"
module return_and_rotate_exec #(
   parameter DATA_W = `DATA_W,
   parameter PC_W = `PC_W,
   parameter FADDR_W = `FADDR_W
) (
   input wire ref_clk_i,
   input wire reset_n_i,
   input wire op_valid_i,
   input wire [`OPCODE_W-1:0] opcode_i,
   input wire [PC_W-1:0] stack_top_entry_i,
   input wire [DATA_W-1:0] file_data_i,
   input wire carry_i,
   output reg stack_pop_o,
   output reg pc_load_o,
   output reg [PC_W-1:0] pc_value_o,
   output reg w_write_o,
   output reg [DATA_W-1:0] w_data_o,
   output reg file_write_o,
   output reg [FADDR_W-1:0] file_addr_o,
   output reg [DATA_W-1:0] file_data_o,
   output reg carry_write_o,
   output reg carry_o,
   output reg busy_o,
   output reg done_o
);
   localparam S_IDLE = 1'b0;
   localparam S_RET2 = 1'b1;
   localparam [1:0] K_NONE = 2'h0;
   localparam [1:0] K_RET = 2'h1;
   localparam [1:0] K_RET_LIT = 2'h2;
   localparam [1:0] K_ROT = 2'h3;

   function [1:0] classify;
      input [`OPCODE_W-1:0] op;
      begin
         if (op == `OP_RETURN)
            classify = K_RET;
         else if ((op & `OP_RET_LIT_MASK) == `OP_RET_LIT_CODE)
            classify = K_RET_LIT;
         else if (((op & `OP_ROT_MASK) == `OP_ROT_LEFT_CODE) ||
                  ((op & `OP_ROT_MASK) == `OP_ROT_RIGHT_CODE))
            classify = K_ROT;
         else
            classify = K_NONE;
      end
   endfunction

   // Rotate direction from the opcode
   function rot_is_left;
      input [`OPCODE_W-1:0] op;
      begin
         rot_is_left = (op & `OP_ROT_MASK) == `OP_ROT_LEFT_CODE;
      end
   endfunction

   // Destination select of a rotate
   function dest_is_file;
      input [`OPCODE_W-1:0] op;
      begin
         dest_is_file = op[`DEST_BIT];
      end
   endfunction

   reg state;
   reg next_state;
   reg next_stack_pop;
   reg next_pc_load;
   reg [PC_W-1:0] next_pc_value;
   reg next_w_write;
   reg [DATA_W-1:0] next_w_data;
   reg next_file_write;
   reg [FADDR_W-1:0] next_file_addr;
   reg [DATA_W-1:0] next_file_data;
   reg next_carry_write;
   reg next_carry;
   reg next_busy;
   reg next_done;
   wire accept;
   wire [1:0] kind;
   wire rot_left;
   wire [DATA_W-1:0] rot_result;
   wire rot_carry;

   assign kind = classify(opcode_i);
   assign rot_left = rot_is_left(opcode_i);
   // New work only taken in idle
   assign accept = op_valid_i && (state == S_IDLE);

   rotate_unit #(
      .WIDTH(DATA_W)
   ) u_rotate (
      .operand_i(file_data_i),
      .carry_i(carry_i),
      .dir_left_i(rot_left),
      .result_o(rot_result),
      .carry_o(rot_carry)
   );

   // Next values: pulses default low, data holds
   always @* begin
      next_state = state;
      next_stack_pop = 1'b0;
      next_pc_load = 1'b0;
      next_pc_value = pc_value_o;
      next_w_write = 1'b0;
      next_w_data = w_data_o;
      next_file_write = 1'b0;
      next_file_addr = file_addr_o;
      next_file_data = file_data_o;
      next_carry_write = 1'b0;
      next_carry = carry_o;
      next_busy = busy_o;
      next_done = 1'b0;
      case (state)
         S_IDLE: begin
            if (accept) begin
               case (kind)
                  K_RET: begin
                     // Pop and load PC, no flag write
                     next_stack_pop = 1'b1;
                     next_pc_load = 1'b1;
                     next_pc_value = stack_top_entry_i;
                     next_busy = 1'b1;
                     next_state = S_RET2;
                  end
                  K_RET_LIT: begin
                     next_stack_pop = 1'b1;
                     next_pc_load = 1'b1;
                     next_pc_value = stack_top_entry_i;
                     next_w_write = 1'b1;
                     next_w_data = opcode_i[DATA_W-1:0];
                     next_busy = 1'b1;
                     next_state = S_RET2;
                  end
                  K_ROT: begin
                     // Only carry flag updated, single cycle
                     next_carry_write = 1'b1;
                     next_carry = rot_carry;
                     next_file_addr = opcode_i[FADDR_W-1:0];
                     if (dest_is_file(opcode_i)) begin
                        next_file_write = 1'b1;
                        next_file_data = rot_result;
                     end else begin
                        next_w_write = 1'b1;
                        next_w_data = rot_result;
                     end
                     next_done = 1'b1;
                  end
                  default: begin
                     next_done = 1'b0;
                  end
               endcase
            end
         end
         S_RET2: begin
            // Second cycle of a return
            next_busy = 1'b0;
            next_done = 1'b1;
            next_state = S_IDLE;
         end
         default: begin
            next_state = S_IDLE;
            next_busy = 1'b0;
         end
      endcase
   end

   // Control state and strobes
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= S_IDLE;
         stack_pop_o <= 1'b0;
         pc_load_o <= 1'b0;
         w_write_o <= 1'b0;
         file_write_o <= 1'b0;
         carry_write_o <= 1'b0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         state <= next_state;
         stack_pop_o <= next_stack_pop;
         pc_load_o <= next_pc_load;
         w_write_o <= next_w_write;
         file_write_o <= next_file_write;
         carry_write_o <= next_carry_write;
         busy_o <= next_busy;
         done_o <= next_done;
      end
   end

   // Data outputs, held until the next write
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pc_value_o <= {PC_W{1'b0}};
         w_data_o <= {DATA_W{1'b0}};
         file_addr_o <= {FADDR_W{1'b0}};
         file_data_o <= {DATA_W{1'b0}};
         carry_o <= 1'b0;
      end else begin
         pc_value_o <= next_pc_value;
         w_data_o <= next_w_data;
         file_addr_o <= next_file_addr;
         file_data_o <= next_file_data;
         carry_o <= next_carry;
      end
   end
endmodule // return_and_rotate_exec
`default_nettype wire

// File: tb/rr_exec_chk.sv
// Purpose: Checker for the return and rotate block
// Assumes: Default widths, one clock
// Notes: Bound to the top module
`timescale 1ns/100ps
`default_nettype none
module rr_exec_chk (
   input wire ref_clk_i, input wire reset_n_i, input wire op_valid_i,
   input wire [13:0] opcode_i, input wire [14:0] stack_top_entry_i,
   input wire [7:0] file_data_i, input wire carry_i,
   input wire stack_pop_o, input wire pc_load_o, input wire [14:0] pc_value_o,
   input wire w_write_o, input wire [7:0] w_data_o, input wire file_write_o,
   input wire [6:0] file_addr_o, input wire [7:0] file_data_o,
   input wire carry_write_o, input wire carry_o, input wire busy_o,
   input wire done_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   wire go = op_valid_i && !busy_o;
   wire ret = go && opcode_i == 14'h0008;
   wire lit = go && (opcode_i & 14'h3f00) == 14'h3400;
   wire rl = go && (opcode_i & 14'h3f00) == 14'h0d00;
   wire rr = go && (opcode_i & 14'h3f00) == 14'h0c00;
   wire other = go && !(ret || lit || rl || rr);
   a_ret_pops: assert property (ret |=> stack_pop_o && pc_load_o && !w_write_o
      && pc_value_o == $past(stack_top_entry_i) ##1 done_o && !stack_pop_o)
      else $error("return wrong");
   a_lit_w_load: assert property (lit |=> w_write_o
      && w_data_o == $past(opcode_i[7:0])) else $error("literal wrong");
   a_lit_pops: assert property (lit |=> stack_pop_o && busy_o ##1 done_o)
      else $error("literal pop wrong");
   a_ret_no_flags: assert property (ret || lit |=> !carry_write_o [*2])
      else $error("flag written");
   a_rl_value: assert property (rl |=> done_o && carry_write_o
      && carry_o == $past(file_data_i[7])
      && ($past(opcode_i[7]) ? file_data_o : w_data_o)
         == {$past(file_data_i[6:0]), $past(carry_i)})
      else $error("left rotate wrong");
   a_rr_result: assert property (rr |=> carry_write_o
      && ($past(opcode_i[7]) ? file_data_o : w_data_o)
         == {$past(carry_i), $past(file_data_i[7:1])})
      else $error("right result wrong");
   a_other_quiet: assert property (other |=> !stack_pop_o && !w_write_o
      && !file_write_o && !carry_write_o && !done_o)
      else $error("unknown opcode acted");
   a_rl_dest: assert property (rl |=> file_write_o == $past(opcode_i[7])
      && w_write_o != $past(opcode_i[7])) else $error("left dest");
   a_rr_value: assert property (rr |=> done_o && carry_o == $past(file_data_i[0])
      && !stack_pop_o) else $error("right rotate wrong");
   a_rr_dest: assert property (rr && opcode_i[7] |=> file_write_o && !w_write_o
      && file_addr_o == $past(opcode_i[6:0])) else $error("right dest");
   c_ret: cover property (ret);
   c_lit: cover property (lit);
   c_rot: cover property (rl ##2 rr);
   c_other: cover property (other);
endmodule // rr_exec_chk
bind return_and_rotate_exec rr_exec_chk u_chk (.*);
`default_nettype wire

// File: tb/return_and_rotate_exec_bench.sv
// Purpose: Bench for the return and rotate block
// Assumes: Outputs valid one edge after accept
// Notes: Fixed waits follow the hand-over timing
`timescale 1ns/100ps
`default_nettype none
module return_and_rotate_exec_bench;
   logic ref_clk_i = 0, reset_n_i = 0, op_valid_i = 0, carry_i = 0;
   logic [13:0] opcode_i = 14'h0000;
   logic [14:0] stack_top_entry_i = 15'h0000;
   logic [7:0] file_data_i = 8'h00;
   wire stack_pop_o, pc_load_o, w_write_o, file_write_o, carry_write_o;
   wire carry_o, busy_o, done_o;
   wire [14:0] pc_value_o;
   wire [7:0] w_data_o, file_data_o;
   wire [6:0] file_addr_o;
   int failures = 0, tests_run = 0;
   return_and_rotate_exec uut (.*);
   initial forever #5 ref_clk_i = ~ref_clk_i;
   task chk(input bit ok, input string m);
      tests_run++;
      if (!ok) begin
         failures++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task issue(input [13:0] op, input [7:0] f, input c, input [14:0] t);
      @(posedge ref_clk_i);
      op_valid_i <= 1; opcode_i <= op; file_data_i <= f; carry_i <= c;
      stack_top_entry_i <= t;
      @(posedge ref_clk_i);
      op_valid_i <= 0;
      #1;
   endtask
   task t_return(input [13:0] op, input [14:0] t, input lw);
      issue(op, 8'h00, 1, t);
      chk(stack_pop_o === 1 && pc_load_o === 1 && pc_value_o === t, "pop");
      chk(w_write_o === lw && carry_write_o === 0 && busy_o === 1, "w");
      if (lw) chk(w_data_o === op[7:0], "literal");
      @(posedge ref_clk_i); #1;
      chk(done_o === 1 && stack_pop_o === 0 && busy_o === 0, "end");
   endtask
   task t_rotate(input [13:0] op, input [7:0] f, input c);
      logic [7:0] r;
      logic nc;
      r = op[8] ? {f[6:0], c} : {c, f[7:1]};
      nc = op[8] ? f[7] : f[0];
      issue(op, f, c, 15'h0000);
      chk(done_o === 1 && carry_write_o === 1 && carry_o === nc, "c");
      if (op[7]) chk(file_write_o === 1 && w_write_o === 0 && file_data_o === r
         && file_addr_o === op[6:0], "f");
      else chk(w_write_o === 1 && file_write_o === 0 && w_data_o === r, "w");
   endtask
   task t_other(input [13:0] op);
      issue(op, 8'h55, 1, 15'h1234);
      chk(stack_pop_o === 0 && w_write_o === 0 && file_write_o === 0
         && carry_write_o === 0 && done_o === 0 && busy_o === 0, "other");
   endtask
   task t_refuse;
      @(posedge ref_clk_i);
      op_valid_i <= 1;
      opcode_i <= 14'h0008;
      stack_top_entry_i <= 15'h0123;
      @(posedge ref_clk_i);
      opcode_i <= 14'h0d80;
      file_data_i <= 8'h80;
      carry_i <= 0;
      @(posedge ref_clk_i);
      op_valid_i <= 0;
      #1;
      chk(done_o === 1 && carry_write_o === 0 && file_write_o === 0, "busy");
      @(posedge ref_clk_i);
      #1;
      chk(carry_write_o === 0 && file_write_o === 0 && done_o === 0, "late");
   endtask
   task complete_run;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge ref_clk_i);
      reset_n_i <= 1;
      t_return(14'h0008, 15'h2abc, 0);
      t_return(14'h3400, 15'h7fff, 1);
      t_return(14'h34ff, 15'h0001, 1);
      t_refuse;
      t_other(14'h0100);
      t_rotate(14'h0d05, 8'he6, 0);
      t_rotate(14'h0dff, 8'h81, 1);
      t_rotate(14'h0c00, 8'h01, 1);
      t_rotate(14'h0c85, 8'h7e, 0);
      complete_run;
   end
endmodule // return_and_rotate_exec_bench
`default_nettype wire
